// >>> psv_pkg.sv
// shared constants and carrier types for the processor supervisor
package psv_pkg;

    // clock rate
    localparam int unsigned CLK_HZ = 125_000_000;
    // timebase tick period in microseconds and its cycle count
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;

    // watchdog periods in milliseconds, one per select level
    localparam int unsigned WD_LOW_MS = 150;
    localparam int unsigned WD_OPEN_MS = 600;
    localparam int unsigned WD_HIGH_MS = 1200;

    // reset stretch, least 250 ms, longest 1000 ms
    localparam int unsigned STRETCH_MS = 250;
    localparam int unsigned STRETCH_MAX_MS = 1000;

    // button debounce: reject below 1 ms, accept by 20 ms
    localparam int unsigned DEBOUNCE_MIN_MS = 1;
    localparam int unsigned DEBOUNCE_MAX_MS = 20;
    localparam int unsigned DEBOUNCE_MS = 2;

    // timeout select levels
    typedef enum logic [1:0] {
        PSV_SEL_LOW,
        PSV_SEL_OPEN,
        PSV_SEL_HIGH
    } psv_sel_type;

    // reset source flags carried together
    typedef struct packed {
        logic power;
        logic button;
        logic watchdog;
    } psv_src_type;

endpackage : psv_pkg

// >>> psv_sync.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module psv_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // first stage is read only by the second stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= INIT;
            sync_out <= INIT;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // psv_sync

// >>> psv_tick.sv
// millisecond timebase tick generator
`timescale 1ns/1ps
module psv_tick #(
    parameter int unsigned TICK_CYCLES = psv_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // one-cycle pulse per tick
    output logic tick
);

    localparam int CW = $clog2(TICK_CYCLES + 1);
    logic [CW-1:0] cnt_q;

    // free-running divider; every interval counts these ticks
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (cnt_q == CW'(TICK_CYCLES - 1)) begin
            cnt_q <= '0;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + CW'(1);
            tick <= 1'b0;
        end
    end

endmodule // psv_tick

// >>> psv_supervisor.sv
// processor supervisor: power, button and watchdog reset generator
`timescale 1ns/1ps

// Notes on behaviour
// - select picks 150, 600 or 1200 ms
// - strobe falling edge restarts watchdog period
// - missed strobe period asserts both resets
// - held button asserts reset within 1-20 ms
// - debounce rejects under 1 ms, accepts 20
// - button release stretches reset 250-1000 ms
// - power-fail drives both resets active
// - reset held 250 ms after power returns
// - two outputs, high and open-drain low
// - button input pulled up internally
// - watchdog counts only while resets inactive
// - watchdog timeout stretches reset 250 ms
module psv_supervisor #(
    parameter int unsigned TICK_CYCLES = psv_pkg::TICK_CYC,
    parameter int unsigned WD_LOW_MS = psv_pkg::WD_LOW_MS,
    parameter int unsigned WD_OPEN_MS = psv_pkg::WD_OPEN_MS,
    parameter int unsigned WD_HIGH_MS = psv_pkg::WD_HIGH_MS,
    parameter int unsigned STRETCH_MS = psv_pkg::STRETCH_MS,
    parameter int unsigned DEBOUNCE_MS = psv_pkg::DEBOUNCE_MS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // supply monitor and configuration pins
    input wire logic power_fail,
    input wire logic [1:0] timeout_select,
    input wire logic supply_tolerance_select,
    // host side pins
    input wire logic manual_reset_button_n,
    input wire logic manual_reset_button_n_oe_n,
    input wire logic watchdog_strobe_n,
    // reset outputs
    output logic reset_out,
    output logic reset_out_n_o,
    output logic reset_out_n_oe_n,
    // threshold choice handed to the analog comparator
    output logic supply_trip_threshold
);

    localparam int TW = 11;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers and timebase

    logic [4:0] pins_s;
    logic pf_s;
    logic btn_s;
    logic stb_s;
    logic tol_s;
    logic [1:0] sel_s;
    logic tick;

    // button level and its drive enable are both pins, so both pass the
    // synchroniser before the pull-up choice is made
    psv_sync #(.WIDTH(5), .INIT(5'h1D)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in({power_fail, manual_reset_button_n, watchdog_strobe_n,
                   supply_tolerance_select, manual_reset_button_n_oe_n}),
        .sync_out(pins_s)
    );

    psv_sync #(.WIDTH(2), .INIT(2'h0)) u_sync_sel (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(timeout_select),
        .sync_out(sel_s)
    );

    assign pf_s = pins_s[4];
    // undriven button reads high, as the internal pull-up would give
    assign btn_s = pins_s[0] ? 1'b1 : pins_s[3];
    assign stb_s = pins_s[2];
    assign tol_s = pins_s[1];

    psv_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // power-fail path with power-up stretch

    logic [TW-1:0] pwr_cnt_q;
    logic pwr_act_q;

    // held from reset release, restarted while power is bad
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_cnt_q <= '0;
            pwr_act_q <= 1'b1;
        end else if (pf_s) begin
            pwr_cnt_q <= '0;
            pwr_act_q <= 1'b1;
        end else if (pwr_act_q && tick) begin
            if (pwr_cnt_q == TW'(STRETCH_MS)) begin
                pwr_act_q <= 1'b0;
            end else begin
                pwr_cnt_q <= pwr_cnt_q + TW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // button debounce and release stretch

    logic [TW-1:0] deb_cnt_q;
    logic btn_low_q;
    logic [TW-1:0] btn_cnt_q;
    logic btn_act_q;

    // low must persist for the debounce count of ticks; a high restarts it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            deb_cnt_q <= '0;
            btn_low_q <= 1'b0;
        end else if (btn_s) begin
            deb_cnt_q <= '0;
            btn_low_q <= 1'b0;
        end else if (tick && !btn_low_q) begin
            if (deb_cnt_q == TW'(DEBOUNCE_MS)) begin
                btn_low_q <= 1'b1;
            end else begin
                deb_cnt_q <= deb_cnt_q + TW'(1);
            end
        end
    end

    // stretch counts from the release of the debounced press
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            btn_cnt_q <= '0;
            btn_act_q <= 1'b0;
        end else if (btn_low_q) begin
            btn_cnt_q <= '0;
            btn_act_q <= 1'b1;
        end else if (btn_act_q && tick) begin
            if (btn_cnt_q == TW'(STRETCH_MS)) begin
                btn_act_q <= 1'b0;
            end else begin
                btn_cnt_q <= btn_cnt_q + TW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog

    logic stb_prev_q;
    logic stb_fall;
    logic [TW-1:0] wd_limit;
    logic [TW-1:0] wd_cnt_q;
    logic [TW-1:0] wd_hold_q;
    logic wd_act_q;
    psv_pkg::psv_src_type src;
    logic any_src;

    // previous strobe level for edge detection
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stb_prev_q <= 1'b1;
        end else begin
            stb_prev_q <= stb_s;
        end
    end

    assign stb_fall = stb_prev_q && !stb_s;

    // open level decodes as the middle period; unused code acts as open
    always_comb begin
        unique case (sel_s)
            psv_pkg::PSV_SEL_LOW: wd_limit = TW'(WD_LOW_MS);
            psv_pkg::PSV_SEL_HIGH: wd_limit = TW'(WD_HIGH_MS);
            default: wd_limit = TW'(WD_OPEN_MS);
        endcase
    end

    // sources gathered in one carrier, any one of them holds reset
    assign src = '{power: pwr_act_q, button: btn_act_q | btn_low_q,
                   watchdog: wd_act_q};
    assign any_src = |src;

    // period counter frozen at zero while any reset is active
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_cnt_q <= '0;
        end else if (any_src || reset_out || stb_fall) begin
            wd_cnt_q <= '0;
        end else if (tick) begin
            wd_cnt_q <= wd_cnt_q + TW'(1);
        end
    end

    // timeout raises a stretched reset; it waits for a full period of
    // ticks, so a host strobing inside the period can never trip it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_hold_q <= '0;
            wd_act_q <= 1'b0;
        end else if (!any_src && !reset_out && !stb_fall && tick
                     && wd_cnt_q >= wd_limit) begin
            wd_hold_q <= '0;
            wd_act_q <= 1'b1;
        end else if (wd_act_q && tick) begin
            if (wd_hold_q == TW'(STRETCH_MS)) begin
                wd_act_q <= 1'b0;
            end else begin
                wd_hold_q <= wd_hold_q + TW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // both pins from flip-flops, toggled together
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_out <= 1'b1;
            reset_out_n_o <= 1'b0;
            reset_out_n_oe_n <= 1'b0;
            supply_trip_threshold <= 1'b0;
        end else begin
            reset_out <= any_src;
            reset_out_n_o <= 1'b0;
            reset_out_n_oe_n <= !any_src;
            supply_trip_threshold <= tol_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic [TW-1:0] out_age_q;

    // cycles-free measure of how long reset has been asserted, in ticks
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_age_q <= '0;
        end else if (!reset_out) begin
            out_age_q <= '0;
        end else if (tick && out_age_q != '1) begin
            out_age_q <= out_age_q + TW'(1);
        end
    end

    pins_together_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reset_out == !reset_out_n_oe_n)
        else $error("reset outputs disagree");

    power_fail_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pf_s |-> ##[1:2] reset_out)
        else $error("power fail did not assert reset");

    stretch_min_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(reset_out) |-> $past(out_age_q) >= TW'(STRETCH_MS))
        else $error("reset released too early");

    button_assert_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(btn_low_q) |=> reset_out)
        else $error("debounced button did not assert reset");

    button_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        btn_low_q |-> btn_act_q || $rose(btn_low_q))
        else $error("button stretch not armed");

    strobe_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        stb_fall |=> wd_cnt_q == '0)
        else $error("strobe did not clear watchdog");

    wd_frozen_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reset_out |=> wd_cnt_q == '0)
        else $error("watchdog counted during reset");

    wd_timeout_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(wd_act_q) |-> $past(wd_cnt_q) >= $past(wd_limit))
        else $error("watchdog fired early");

    wd_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(wd_act_q) |-> $past(wd_hold_q) == TW'(STRETCH_MS))
        else $error("watchdog stretch ended early");

    btn_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(btn_act_q) |-> $past(btn_cnt_q) == TW'(STRETCH_MS))
        else $error("button stretch ended early");

    wd_fresh_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(reset_out) |-> wd_cnt_q == '0)
        else $error("watchdog period not fresh at release");

    any_source_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (pwr_act_q || btn_act_q || wd_act_q) |=> reset_out)
        else $error("active source without reset");

    deb_reject_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(btn_low_q) |-> $past(deb_cnt_q) == TW'(DEBOUNCE_MS))
        else $error("button accepted without full debounce");

endmodule // psv_supervisor

// >>> psv_host_model.sv
// host processor model that strobes the watchdog input
`timescale 1ns/1ps
module psv_host_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // control from the bench
    input wire logic run,
    input wire logic [7:0] gap,
    // supervisor pins
    input wire logic reset_out,
    output logic watchdog_strobe_n
);
    logic [7:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////
    // low pulse of 3 cycles every gap+1 cycles; a host held in reset is mute
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            watchdog_strobe_n <= 1'b1;
        end else if (!run || reset_out) begin
            cnt_q <= 8'h00;
            watchdog_strobe_n <= 1'b1;
        end else begin
            cnt_q <= (cnt_q == gap) ? 8'h00 : cnt_q + 8'h01;
            watchdog_strobe_n <= (cnt_q > 8'h02);
        end
    end
endmodule // psv_host_model

// >>> tb_psv_supervisor.sv
// self-checking bench for the processor supervisor
`timescale 1ns/1ps
module tb_psv_supervisor;
    // shrunk timebase: one tick is 10 cycles
    localparam int T = 10;
    localparam int STR = 8;
    logic sys_clk, rst_n, power_fail, tol_sel, button_n, button_oe_n;
    logic run, reset_out, reset_out_n_o, reset_out_n_oe_n, threshold;
    logic strobe_n;
    logic [1:0] sel;
    int fails, total_checks, n;

    ////////////////////////////////////////////////////////////////////////
    psv_supervisor #(.TICK_CYCLES(T), .WD_LOW_MS(5), .WD_OPEN_MS(10),
        .WD_HIGH_MS(20), .STRETCH_MS(STR), .DEBOUNCE_MS(2))
    psv_supervisor_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .power_fail(power_fail), .timeout_select(sel),
        .supply_tolerance_select(tol_sel),
        .manual_reset_button_n(button_n),
        .manual_reset_button_n_oe_n(button_oe_n),
        .watchdog_strobe_n(strobe_n), .reset_out(reset_out),
        .reset_out_n_o(reset_out_n_o), .reset_out_n_oe_n(reset_out_n_oe_n),
        .supply_trip_threshold(threshold));

    // gap of 30 stays inside the shortest period of 50 cycles
    psv_host_model psv_host_model_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .run(run), .gap(8'h1E), .reset_out(reset_out),
        .watchdog_strobe_n(strobe_n));

    ////////////////////////////////////////////////////////////////////////
    // compare tasks, one per kind of result
    task automatic check_bit(string what, logic exp, logic seen);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic check_range(string what, int lo, int hi, int seen);
        total_checks++;
        if (seen < lo || seen > hi) begin
            fails++;
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, seen);
        end
    endtask

    // bounded wait for a reset level; the two outputs are paired each cycle
    task automatic wait_for(logic v, int max, output int cnt);
        cnt = 0;
        while (reset_out !== v && cnt < max) begin
            @(posedge sys_clk);
            #1;
            cnt++;
            check_bit("reset_pair", ~reset_out, reset_out_n_oe_n);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_powerup();
        wait_for(1'b0, 60 * T, n);
        check_range("powerup_reset_time", STR * T, 4 * STR * T, n);
        check_bit("reset_out_n_o", 1'b0, reset_out_n_o);
        check_bit("supply_trip_threshold", 1'b0, threshold);
        @(posedge sys_clk);
        tol_sel <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        check_bit("supply_trip_threshold", 1'b1, threshold);
    endtask

    task automatic t_power_fail();
        @(posedge sys_clk);
        power_fail <= 1'b1;
        wait_for(1'b1, 10, n);
        check_range("power_fail_delay", 1, 4, n);
        repeat (50) @(posedge sys_clk);
        #1;
        check_bit("reset_out", 1'b1, reset_out);
        @(posedge sys_clk);
        power_fail <= 1'b0;
        wait_for(1'b0, 60 * T, n);
        check_range("resume_reset_time", STR * T, 4 * STR * T, n);
    endtask

    task automatic t_button();
        @(posedge sys_clk);
        button_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        button_n <= 1'b1;
        wait_for(1'b1, 8 * T, n);
        check_bit("short_press", 1'b0, reset_out);
        @(posedge sys_clk);
        button_oe_n <= 1'b1;
        button_n <= 1'b0;
        wait_for(1'b1, 8 * T, n);
        check_bit("undriven_button", 1'b0, reset_out);
        @(posedge sys_clk);
        button_oe_n <= 1'b0;
        wait_for(1'b1, 25 * T, n);
        check_range("button_to_reset_delay", T, 20 * T, n);
        repeat (10 * T) @(posedge sys_clk);
        button_n <= 1'b1;
        wait_for(1'b0, 60 * T, n);
        check_range("button_release_time", STR * T, 4 * STR * T, n);
    endtask

    // second period is timed from the release, so it starts fresh
    task automatic t_watchdog(logic [1:0] code, int ms);
        @(posedge sys_clk);
        sel <= code;
        run <= 1'b1;
        wait_for(1'b1, 3 * ms * T, n);
        check_bit("strobed_reset", 1'b0, reset_out);
        @(posedge sys_clk);
        run <= 1'b0;
        wait_for(1'b1, 3 * ms * T, n);
        wait_for(1'b0, 60 * T, n);
        check_range("watchdog_reset_time", STR * T, 4 * STR * T, n);
        wait_for(1'b1, 3 * ms * T, n);
        check_range("watchdog_period", ms * T, (ms + 2) * T, n);
        wait_for(1'b0, 60 * T, n);
        @(posedge sys_clk);
        run <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        power_fail = 1'b0;
        tol_sel = 1'b0;
        button_n = 1'b1;
        button_oe_n = 1'b0;
        run = 1'b1;
        sel = 2'b00;
        fails = 0;
        total_checks = 0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_powerup();
        t_power_fail();
        t_button();
        t_watchdog(2'b00, 5);
        t_watchdog(2'b01, 10);
        t_watchdog(2'b10, 20);
        t_watchdog(2'b11, 10);
        conclude();
    end

    // hang guard, well beyond the few thousand cycles the tests take
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        conclude();
    end
endmodule // tb_psv_supervisor
